// ===== glm_pkg.sv
// Purpose: shared constants for genset load management
// Assumes: 200 MHz clk, timers counted in milliseconds
// Notes:   register map is a plain address/strobe port
package glm_pkg;
    localparam int          CLK_HZ        = 200_000_000;
    localparam int          MS_TICKS      = CLK_HZ / 1000;
    localparam int          PULSE_MS      = 250;
    localparam int          PWR_W         = 16;
    localparam int          TMR_W         = 16;
    localparam int          NSTEP         = 5;
    localparam int          NOUT          = 4;
    localparam logic [3:0]  A_SHED_LO     = 4'h0;
    localparam logic [3:0]  A_SHED_HI     = 4'h1;
    localparam logic [3:0]  A_SAME_GUARD  = 4'h2;
    localparam logic [3:0]  A_CROSS_GUARD = 4'h3;
    localparam logic [3:0]  A_STEP_ADD_LV = 4'h4;
    localparam logic [3:0]  A_STEP_SUB_LV = 4'h5;
    localparam logic [3:0]  A_ADD_START   = 4'h6;
    localparam logic [3:0]  A_ADD_WAIT    = 4'h7;
    localparam logic [3:0]  A_SUB_START   = 4'h8;
    localparam logic [3:0]  A_SUB_WAIT    = 4'h9;
    localparam logic [3:0]  A_ROUTE       = 4'hA;
    localparam logic [3:0]  A_STATUS      = 4'hB;
    localparam logic [31:0] UNMAPPED_VAL  = 32'h0000_0000;
    localparam logic [2:0]  RT_OFF        = 3'h0;
    localparam logic [2:0]  RT_SHED       = 3'h1;
    localparam logic [2:0]  RT_DUMMY      = 3'h2;
    localparam logic [2:0]  RT_ADD        = 3'h3;
    localparam logic [2:0]  RT_SUB        = 3'h4;
endpackage : glm_pkg

// ===== glm_timer.sv
// Purpose: millisecond down-counter with load and done flag
// Assumes: msTick is a one-cycle enable every millisecond
// Notes:   done reads the count only; a load shows one cycle later
`timescale 1ns/100ps
`default_nettype none
module glm_timer import glm_pkg::*; #(
    parameter int W = TMR_W
) (
    input  wire logic         clk,    // system clock
    input  wire logic         rst_n,  // async reset, low
    input  wire logic         msTick, // 1 ms enable
    input  wire logic         load,   // start timing
    input  wire logic [W-1:0] ms,     // duration in ms
    output logic              done    // time elapsed
);
    typedef struct packed {
        logic [W-1:0] cnt;
    } glm_tmr_t;
    glm_tmr_t st_r, st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (load) begin
            st_nxt.cnt = ms;
        end else if (msTick && st_r.cnt != '0) begin
            st_nxt.cnt = st_r.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // load kept out of done: callers load on done, which would loop back
    assign done = (st_r.cnt == '0);
endmodule // glm_timer
`default_nettype wire

// ===== glm_load_mgmt.sv
// Purpose: threshold-and-timer load management for a genset controller
// Assumes: power samples are signed and arrive with a valid strobe
// Notes:   all times are programmed in milliseconds
// Operation
// - shedding output sets when power exceeds shedding high limit
// - shedding clears below low limit, holds state between limits
// - shedding comparison always runs out of reset, no enable
// - dummy-load output is the inverse of shedding
// - each digital output can route shedding, add or subtract
// - add output on below low limit, off above it
// - subtract output on above high limit, off below it
// - same-direction guard spaces two adds or two subtracts
// - cross-direction guard spaces an add and a subtract
// - add held off until cross guard ends, then only if still low
// - five steps, added from one, removed from highest connected
// - step add after power stays below add level for start delay
// - step remove after power stays above sub level for start delay
// - step adds spaced by add wait, condition rechecked after both
// - step subtracts spaced by subtract wait, condition rechecked after both
// - step outputs are single fixed 250 ms pulses
// - with wait elapsed, subtract fires right after start delay
`timescale 1ns/100ps
`default_nettype none
module glm_load_mgmt import glm_pkg::*; #(
    parameter int MS_CYC = MS_TICKS,  // cycles per millisecond
    parameter int PLS_MS = PULSE_MS   // step pulse width in ms
) (
    input  wire logic                    clk,       // system clock
    input  wire logic                    rst_n,     // async reset, low
    input  wire logic signed [PWR_W-1:0] pwrSample, // genset power
    input  wire logic                    pwrValid,  // sample strobe
    input  wire logic [3:0]              regAddr,   // register address
    input  wire logic [31:0]             regWdata,  // write data
    input  wire logic                    regWr,     // write strobe
    input  wire logic                    regRd,     // read strobe
    output logic [31:0]                  regRdata,  // read data
    output logic                         shedOut,   // shedding level
    output logic                         dummyOut,  // dummy-load level
    output logic                         addOut,    // load add level
    output logic                         subOut,    // load subtract level
    output logic [NSTEP-1:0]             stepAdd,   // step add pulses
    output logic [NSTEP-1:0]             stepSub,   // step subtract pulses
    output logic [NOUT-1:0]              digOut     // routed outputs
);
    localparam int DIV_W = $clog2(MS_CYC);
    typedef enum logic [2:0] {
        SQ_IDLE = 3'b001,
        SQ_ADD  = 3'b010,
        SQ_SUB  = 3'b100
    } glm_sq_t;

    typedef struct packed {
        logic signed [PWR_W-1:0] shedLo;
        logic signed [PWR_W-1:0] shedHi;
        logic [TMR_W-1:0]        sameG;
        logic [TMR_W-1:0]        crossG;
        logic signed [PWR_W-1:0] addLv;
        logic signed [PWR_W-1:0] subLv;
        logic [TMR_W-1:0]        addStart;
        logic [TMR_W-1:0]        addWait;
        logic [TMR_W-1:0]        subStart;
        logic [TMR_W-1:0]        subWait;
        logic [3*NOUT-1:0]       route;
        logic                    below;
        logic                    above;
        logic                    addBelow;
        logic                    subAbove;
        logic                    shed;
        logic                    add;
        logic                    sub;
        logic [NSTEP-1:0]        conn;
        glm_sq_t                 sq;
        logic [NSTEP-1:0]        pAdd;
        logic [NSTEP-1:0]        pSub;
        logic [31:0]             rdata;
        logic [NOUT-1:0]         dout;
        logic [DIV_W-1:0]        div;
        logic                    tick;
    } glm_st_t;

    glm_st_t st_r, st_nxt;

    // timer controls
    logic addSameLd, subSameLd, crossLd, pulseLd;
    logic aStLd, aWtLd, sStLd, sWtLd;
    logic addSameDn, subSameDn, crossDn, pulseDn;
    logic aStDn, aWtDn, sStDn, sWtDn;
    logic [NOUT*3-1:0] rt;
    logic [NOUT-1:0]   dout_nxt;

    glm_timer u_addSame (.clk(clk), .rst_n(rst_n), .msTick(st_r.tick),
        .load(addSameLd), .ms(st_r.sameG), .done(addSameDn));
    glm_timer u_subSame (.clk(clk), .rst_n(rst_n), .msTick(st_r.tick),
        .load(subSameLd), .ms(st_r.sameG), .done(subSameDn));
    glm_timer u_cross (.clk(clk), .rst_n(rst_n), .msTick(st_r.tick),
        .load(crossLd), .ms(st_r.crossG), .done(crossDn));
    // one extra ms: the first tick may land right after the load
    glm_timer u_pulse (.clk(clk), .rst_n(rst_n), .msTick(st_r.tick),
        .load(pulseLd), .ms(TMR_W'(PLS_MS + 1)), .done(pulseDn));
    glm_timer u_aStart (.clk(clk), .rst_n(rst_n), .msTick(st_r.tick),
        .load(aStLd), .ms(st_r.addStart), .done(aStDn));
    glm_timer u_aWait (.clk(clk), .rst_n(rst_n), .msTick(st_r.tick),
        .load(aWtLd), .ms(st_r.addWait), .done(aWtDn));
    glm_timer u_sStart (.clk(clk), .rst_n(rst_n), .msTick(st_r.tick),
        .load(sStLd), .ms(st_r.subStart), .done(sStDn));
    glm_timer u_sWait (.clk(clk), .rst_n(rst_n), .msTick(st_r.tick),
        .load(sWtLd), .ms(st_r.subWait), .done(sWtDn));

    // one-hot mask of the highest connected step, used for removal order
    function automatic logic [NSTEP-1:0] topOne(input logic [NSTEP-1:0] c);
        logic [NSTEP-1:0] r;
        r = '0;
        for (int i = 0; i < NSTEP; i++) begin
            if (c[i]) begin
                r = '0;
                r[i] = 1'b1;
            end
        end
        return r;
    endfunction

    logic addGo, subGo, stepAddGo, stepSubGo;

    always_comb begin
        st_nxt = st_r;
        addSameLd = 1'b0;
        subSameLd = 1'b0;
        crossLd   = 1'b0;
        pulseLd   = 1'b0;
        aStLd     = 1'b0;
        aWtLd     = 1'b0;
        sStLd     = 1'b0;
        sWtLd     = 1'b0;
        // millisecond enable divider
        st_nxt.tick = 1'b0;
        if (st_r.div == DIV_W'(MS_CYC - 1)) begin
            st_nxt.div  = '0;
            st_nxt.tick = 1'b1;
        end else begin
            st_nxt.div = st_r.div + 1'b1;
        end
        // comparisons refresh on each sample
        if (pwrValid) begin
            st_nxt.above    = pwrSample > st_r.shedHi;
            st_nxt.below    = pwrSample < st_r.shedLo;
            st_nxt.addBelow = pwrSample < st_r.addLv;
            st_nxt.subAbove = pwrSample > st_r.subLv;
        end
        // hysteretic shedding, never gated
        // set wins if the limits overlap, so shedding errs toward safety
        if (st_r.above) begin
            st_nxt.shed = 1'b1;
        end else if (st_r.below) begin
            st_nxt.shed = 1'b0;
        end
        // level add/subtract with guards
        addGo = st_r.below && !st_r.add && addSameDn && crossDn;
        subGo = st_r.above && !st_r.sub && subSameDn && crossDn;
        if (st_r.add && !st_r.below) begin
            st_nxt.add = 1'b0;
        end else if (addGo) begin
            st_nxt.add = 1'b1;
            addSameLd  = 1'b1;
            crossLd    = 1'b1;
        end
        if (st_r.sub && !st_r.above) begin
            st_nxt.sub = 1'b0;
        end else if (subGo && !addGo) begin
            st_nxt.sub = 1'b1;
            subSameLd  = 1'b1;
            crossLd    = 1'b1;
        end
        // start timers restart whenever their condition is broken
        if (!st_r.addBelow) begin
            aStLd = 1'b1;
        end
        if (!st_r.subAbove) begin
            sStLd = 1'b1;
        end
        stepAddGo = st_r.addBelow && aStDn && aWtDn
                    && !(&st_r.conn);
        stepSubGo = st_r.subAbove && sStDn && sWtDn
                    && (|st_r.conn);
        unique case (st_r.sq)
            SQ_IDLE: begin
                if (stepAddGo) begin
                    // lowest free step goes in first
                    st_nxt.pAdd = ~st_r.conn & (st_r.conn + 1'b1);
                    st_nxt.conn = st_r.conn | st_nxt.pAdd;
                    st_nxt.sq   = SQ_ADD;
                    pulseLd     = 1'b1;
                    aWtLd       = 1'b1;
                    aStLd       = 1'b1;
                end else if (stepSubGo) begin
                    st_nxt.pSub = topOne(st_r.conn);
                    st_nxt.conn = st_r.conn & ~st_nxt.pSub;
                    st_nxt.sq   = SQ_SUB;
                    pulseLd     = 1'b1;
                    sWtLd       = 1'b1;
                    sStLd       = 1'b1;
                end
            end
            SQ_ADD, SQ_SUB: begin
                if (pulseDn) begin
                    st_nxt.pAdd = '0;
                    st_nxt.pSub = '0;
                    st_nxt.sq   = SQ_IDLE;
                end
            end
            default: begin
                st_nxt.sq   = SQ_IDLE;
                st_nxt.pAdd = '0;
                st_nxt.pSub = '0;
            end
        endcase
        st_nxt.dout = dout_nxt;
        // register port
        if (regWr) begin
            unique case (regAddr)
                A_SHED_LO:     st_nxt.shedLo   = regWdata[PWR_W-1:0];
                A_SHED_HI:     st_nxt.shedHi   = regWdata[PWR_W-1:0];
                A_SAME_GUARD:  st_nxt.sameG    = regWdata[TMR_W-1:0];
                A_CROSS_GUARD: st_nxt.crossG   = regWdata[TMR_W-1:0];
                A_STEP_ADD_LV: st_nxt.addLv    = regWdata[PWR_W-1:0];
                A_STEP_SUB_LV: st_nxt.subLv    = regWdata[PWR_W-1:0];
                A_ADD_START:   st_nxt.addStart = regWdata[TMR_W-1:0];
                A_ADD_WAIT:    st_nxt.addWait  = regWdata[TMR_W-1:0];
                A_SUB_START:   st_nxt.subStart = regWdata[TMR_W-1:0];
                A_SUB_WAIT:    st_nxt.subWait  = regWdata[TMR_W-1:0];
                A_ROUTE:       st_nxt.route    = regWdata[3*NOUT-1:0];
                default: ;
            endcase
        end
        st_nxt.rdata = '0;
        if (regRd) begin
            unique case (regAddr)
                A_SHED_LO:     st_nxt.rdata = 32'(st_r.shedLo);
                A_SHED_HI:     st_nxt.rdata = 32'(st_r.shedHi);
                A_SAME_GUARD:  st_nxt.rdata = 32'(st_r.sameG);
                A_CROSS_GUARD: st_nxt.rdata = 32'(st_r.crossG);
                A_STEP_ADD_LV: st_nxt.rdata = 32'(st_r.addLv);
                A_STEP_SUB_LV: st_nxt.rdata = 32'(st_r.subLv);
                A_ADD_START:   st_nxt.rdata = 32'(st_r.addStart);
                A_ADD_WAIT:    st_nxt.rdata = 32'(st_r.addWait);
                A_SUB_START:   st_nxt.rdata = 32'(st_r.subStart);
                A_SUB_WAIT:    st_nxt.rdata = 32'(st_r.subWait);
                A_ROUTE:       st_nxt.rdata = 32'(st_r.route);
                A_STATUS:      st_nxt.rdata = 32'({st_r.conn, st_r.sub,
                                   st_r.add, st_r.shed});
                default:       st_nxt.rdata = UNMAPPED_VAL;
            endcase
        end
    end

    // routed digital outputs, one selector per output
    assign rt = st_r.route;
    for (genvar g = 0; g < NOUT; g++) begin : g_route
        always_comb begin
            unique case (rt[3*g +: 3])
                RT_SHED:  dout_nxt[g] = st_r.shed;
                RT_DUMMY: dout_nxt[g] = !st_r.shed;
                RT_ADD:   dout_nxt[g] = st_r.add;
                RT_SUB:   dout_nxt[g] = st_r.sub;
                default:  dout_nxt[g] = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r       <= '0;
            st_r.sq    <= SQ_IDLE;
            st_r.shedLo <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign regRdata = st_r.rdata;
    assign shedOut  = st_r.shed;
    assign dummyOut = !st_r.shed;
    assign addOut   = st_r.add;
    assign subOut   = st_r.sub;
    assign stepAdd  = st_r.pAdd;
    assign stepSub  = st_r.pSub;
    assign digOut   = st_r.dout;

    // assertions
    sequence s_pulse_start;
        $rose(|stepAdd) || $rose(|stepSub);
    endsequence
    sequence s_sub_fire;
        $rose(|stepSub);
    endsequence
    a_shed_sets: assert property (
        @(posedge clk) disable iff (!rst_n) st_r.above |=> shedOut)
        else $error("shed not set");
    a_shed_clears: assert property (
        @(posedge clk) disable iff (!rst_n) st_r.below && !st_r.above
        |=> !shedOut) else $error("shed not cleared");
    a_shed_holds: assert property (
        @(posedge clk) disable iff (!rst_n) !st_r.above && !st_r.below
        |=> $stable(shedOut)) else $error("shed moved between limits");
    a_dummy_inverse: assert property (
        @(posedge clk) disable iff (!rst_n) dummyOut == !shedOut)
        else $error("dummy not inverse");
    a_add_drops: assert property (
        @(posedge clk) disable iff (!rst_n) addOut && !st_r.below
        |=> !addOut) else $error("add stuck");
    a_sub_drops: assert property (
        @(posedge clk) disable iff (!rst_n) subOut && !st_r.above
        |=> !subOut) else $error("sub stuck");
    a_add_same: assert property (
        @(posedge clk) disable iff (!rst_n) $rose(addOut)
        |-> $past(addSameDn)) else $error("add same guard");
    a_sub_guard: assert property (
        @(posedge clk) disable iff (!rst_n) $rose(subOut)
        |-> $past(crossDn) && $past(subSameDn)) else $error("sub guard");
    a_add_guard: assert property (
        @(posedge clk) disable iff (!rst_n) $rose(addOut)
        |-> $past(crossDn)) else $error("cross guard");
    a_add_held: assert property (
        @(posedge clk) disable iff (!rst_n) !addOut && !crossDn
        |=> !addOut) else $error("add during cross guard");
    a_step_onehot: assert property (
        @(posedge clk) disable iff (!rst_n) $onehot0(stepAdd | stepSub))
        else $error("multi step");
    a_add_lowest: assert property (
        @(posedge clk) disable iff (!rst_n) $rose(|stepAdd)
        |-> ((stepAdd - 1'b1) & ~st_r.conn) == '0)
        else $error("add skipped a step");
    a_sub_highest: assert property (
        @(posedge clk) disable iff (!rst_n) s_sub_fire
        |-> (st_r.conn & ~(stepSub - 1'b1)) == '0)
        else $error("sub not from top");
    a_add_start: assert property (
        @(posedge clk) disable iff (!rst_n) $rose(|stepAdd)
        |-> $past(aStDn)) else $error("add start delay");
    a_sub_start: assert property (
        @(posedge clk) disable iff (!rst_n) s_sub_fire
        |-> $past(sStDn) && $past(st_r.subAbove))
        else $error("sub start delay");
    a_add_spacing: assert property (
        @(posedge clk) disable iff (!rst_n) $rose(|stepAdd)
        |-> $past(aWtDn) && $past(st_r.addBelow))
        else $error("add spacing");
    a_sub_spacing: assert property (
        @(posedge clk) disable iff (!rst_n) s_sub_fire
        |-> $past(sWtDn)) else $error("sub spacing");
    a_pulse_hold: assert property (
        @(posedge clk) disable iff (!rst_n) s_pulse_start
        |=> (|(stepAdd | stepSub)) [*8]) else $error("pulse short");
endmodule // glm_load_mgmt
`default_nettype wire

// ===== glm_load_rig.sv
// Purpose: relay-switched load gear on the far side of load management
// Assumes: step outputs are pulses, add/subtract outputs are levels
// Notes:   ramp level only moves while exactly one level output is high
`timescale 1ns/100ps
`default_nettype none
module glm_load_rig import glm_pkg::*; (
    input  wire logic               clk,     // system clock
    input  wire logic               rst_n,   // async reset, low
    input  wire logic               addOut,  // ramp load up
    input  wire logic               subOut,  // ramp load down
    input  wire logic [NSTEP-1:0]   stepAdd, // step connect pulses
    input  wire logic [NSTEP-1:0]   stepSub, // step release pulses
    output logic      [NSTEP-1:0]   conn,    // connected steps
    output logic signed [PWR_W-1:0] rampLvl  // ramped load level
);
    logic [NSTEP-1:0] addPrev;
    logic [NSTEP-1:0] subPrev;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            conn    <= '0;
            addPrev <= '0;
            subPrev <= '0;
            rampLvl <= '0;
        end else begin
            addPrev <= stepAdd;
            subPrev <= stepSub;
            // contactors latch on the leading edge, so a pulse counts once
            conn <= (conn | (stepAdd & ~addPrev)) & ~(stepSub & ~subPrev);
            if (addOut && !subOut) begin
                rampLvl <= rampLvl + 16'sd1;
            end else if (subOut && !addOut) begin
                rampLvl <= rampLvl - 16'sd1;
            end
        end
    end
endmodule // glm_load_rig
`default_nettype wire

// ===== glm_tb.sv
// Purpose: self-checking bench for genset load management
// Assumes: ms tick shortened to 10 cycles, step pulse to 2 ms
// Notes:   read data and step pulses are checked against queued notes
`timescale 1ns/100ps
`default_nettype none
`define CHK(a,b,m) begin compares++; if ((a) !== (b)) begin err_count++; $display("MISMATCH t=%0t %s", $time, m); end end
module tb import glm_pkg::*;;
    localparam int MSC  = 10;
    localparam int PLS  = 2;
    localparam int WAIT = 3;
    logic                    clk;
    logic                    rst_n;
    logic signed [PWR_W-1:0] pwrSample;
    logic                    pwrValid;
    logic [3:0]              regAddr;
    logic [31:0]             regWdata;
    logic                    regWr;
    logic                    regRd;
    wire logic [31:0]        regRdata;
    wire logic               shedOut;
    wire logic               dummyOut;
    wire logic               addOut;
    wire logic               subOut;
    wire logic [NSTEP-1:0]   stepAdd;
    wire logic [NSTEP-1:0]   stepSub;
    wire logic [NOUT-1:0]    digOut;
    wire logic [NSTEP-1:0]   conn;
    wire logic signed [PWR_W-1:0] rampLvl;
    wire logic [9:0]         stp = {stepSub, stepAdd};
    int                      err_count = 0;
    int                      compares = 0;
    integer                  seed = 32'h58bc;
    logic [31:0]             rdQ[$];
    logic [9:0]              stepQ[$];
    logic                    rdPend = 1'b0;
    logic [9:0]              stpPrev = '0;
    int                      cyc = 0;
    int                      wid = 0;
    int                      lastA = -1000;
    int                      lastS = -1000;

    glm_load_mgmt #(.MS_CYC(MSC), .PLS_MS(PLS)) glm_load_mgmt_i (
        .clk(clk), .rst_n(rst_n), .pwrSample(pwrSample),
        .pwrValid(pwrValid), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .shedOut(shedOut), .dummyOut(dummyOut), .addOut(addOut),
        .subOut(subOut), .stepAdd(stepAdd), .stepSub(stepSub),
        .digOut(digOut));
    glm_load_rig glm_load_rig_i (
        .clk(clk), .rst_n(rst_n), .addOut(addOut), .subOut(subOut),
        .stepAdd(stepAdd), .stepSub(stepSub), .conn(conn),
        .rampLvl(rampLvl));

    always #2.5 clk = ~clk;

    task automatic results;
        $display("errors %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        regAddr  <= a;
        regWdata <= d;
        regWr    <= 1'b1;
        @(posedge clk);
        regWr    <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        rdQ.push_back(e);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge clk);
        regRd   <= 1'b0;
        @(posedge clk);
    endtask

    // flags settle two edges after the strobe; four leaves margin
    task automatic pwr(input logic [15:0] v);
        pwrSample <= v;
        pwrValid  <= 1'b1;
        @(posedge clk);
        pwrValid  <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
    endtask

    task automatic waitSteps;
        int n;
        n = 0;
        while (stepQ.size() != 0 && n < 2000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 2000) begin
            err_count++;
            $display("MISMATCH t=%0t step pulses missing", $time);
            results();
        end
        repeat (150) @(posedge clk);
        #1;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (rdPend) `CHK(regRdata, rdQ.size() ? rdQ.pop_front() : '1, "read data")
        rdPend <= regRd;
        if (stpPrev == 0 && stp != 0) begin
            `CHK(stp, stepQ.size() ? stepQ.pop_front() : '1, "step order")
            if (stp[4:0] != 0) begin
                `CHK(cyc - lastA >= (WAIT - 1) * MSC, 1'b1, "add spacing")
                lastA = cyc;
            end else begin
                `CHK(cyc - lastS >= (WAIT - 1) * MSC, 1'b1, "sub spacing")
                lastS = cyc;
            end
        end
        if (stp != 0) wid++;
        if (stp == 0 && stpPrev != 0) begin
            `CHK(wid >= PLS * MSC && wid <= (PLS + 1) * MSC + 2, 1'b1, "width")
            wid = 0;
        end
        stpPrev = stp;
    end

    initial begin
        logic [31:0] v;
        logic [31:0] e;
        int          n;
        clk = 1'b0;
        rst_n = 1'b0;
        pwrSample = '0;
        pwrValid = 1'b0;
        regAddr = '0;
        regWdata = '0;
        regWr = 1'b0;
        regRd = 1'b0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        `CHK({dummyOut, shedOut, addOut, subOut, stp, digOut}, 18'h2_0000, "reset")
        for (int i = 0; i < 12; i++) rd(4'(i), 32'h0000_0000);
        // step levels parked first so random timers cannot fire a step
        wr(A_STEP_ADD_LV, 32'h0000_8000);
        wr(A_STEP_SUB_LV, 32'h0000_7FFF);
        for (int i = 0; i < 11; i++) begin
            if (i == 4 || i == 5) continue;
            v = $random(seed);
            wr(4'(i), v);
            // power limits read back sign-extended, the rest zero-extended
            e = (i == 10) ? 32'h0000_0FFF : 32'h0000_FFFF;
            e = (i < 2) ? 32'(signed'(v[15:0])) : (v & e);
            rd(4'(i), e);
        end
        v = $random(seed);
        wr(4'hC, v);
        rd(4'hC, UNMAPPED_VAL);
        wr(A_SHED_LO, 32'h0000_0064);
        wr(A_SHED_HI, 32'h0000_00C8);
        wr(A_SAME_GUARD, 32'h0000_0001);
        wr(A_CROSS_GUARD, 32'h0000_000A);
        wr(A_ADD_START, 32'h0000_0002);
        wr(A_ADD_WAIT, 32'h0000_0003);
        wr(A_SUB_START, 32'h0000_0002);
        wr(A_SUB_WAIT, 32'h0000_0003);
        wr(A_ROUTE, 32'h0000_08D1);
        pwr(16'h012C);
        `CHK({shedOut, dummyOut, subOut, addOut}, 4'b1010, "above high")
        `CHK(digOut, 4'b1001, "routing")
        v = $random(seed);
        pwr(16'h0065 + 16'(v & 32'h0000_003F));
        `CHK({shedOut, subOut}, 2'b10, "between limits")
        pwr(16'h0032);
        `CHK({shedOut, dummyOut, addOut}, 3'b010, "below low, guarded")
        repeat (20) @(posedge clk);
        #1;
        `CHK(addOut, 1'b0, "cross guard holds add")
        n = 0;
        while (addOut !== 1'b1 && n < 300) begin
            @(posedge clk);
            n++;
        end
        #1;
        `CHK(addOut, 1'b1, "add after cross guard")
        if (n >= 300) results();
        `CHK(digOut, 4'b0110, "routing")
        wr(A_STEP_ADD_LV, 32'h0000_0000);
        for (int i = 0; i < NSTEP; i++) stepQ.push_back(10'(1 << i));
        pwr(16'hFF9C);
        waitSteps();
        `CHK(conn, 5'h1F, "all steps in")
        `CHK(rampLvl > 0, 1'b1, "ramp rose")
        rd(A_STATUS, 32'h0000_00FA);
        wr(A_STEP_ADD_LV, 32'h0000_8000);
        wr(A_STEP_SUB_LV, 32'h0000_0000);
        for (int i = NSTEP - 1; i >= 0; i--) stepQ.push_back(10'(32 << i));
        pwr(16'h012C);
        waitSteps();
        `CHK(conn, 5'h00, "all steps out")
        rd(A_STATUS, 32'h0000_0005);
        repeat (4) @(posedge clk);
        results();
    end
endmodule // tb
`default_nettype wire
